// file: common/afe_regs.svh
`ifndef AFE_REGS_SVH
`define AFE_REGS_SVH
// ************************************************
// serial word layout
// ************************************************
`define AFE_WORD_BITS 11
`define AFE_WORD_CNT_W 4
`define AFE_WORD_LAST 4'hB
`define AFE_SEL_MSB 10
`define AFE_SEL_LSB 8
`define AFE_DATA_MSB 7
// ************************************************
// register selects
// ************************************************
`define AFE_SEL_MODE 3'h6
`define AFE_SEL_NONE 3'h7
// ************************************************
// mode register fields
// ************************************************
`define AFE_MODE_PWR_DOWN 7
`define AFE_MODE_DIG_RESET 6
`define AFE_MODE_TOP_EXT 5
`define AFE_MODE_DC_EXT 4
`define AFE_MODE_AC 3
`define AFE_MODE_INVERT 2
`define AFE_MODE_CFG_MSB 1
`define AFE_MODE_CFG_LSB 0
`define AFE_CFG_RED 2'h0
`define AFE_CFG_ROT_PIX 2'h1
`define AFE_CFG_TRIPLE 2'h2
`define AFE_CFG_ROT_LINE 2'h3
// ************************************************
// power-up values
// ************************************************
`define AFE_GAIN_RST 6'h00
`define AFE_OFFS_RST 8'h40
`define AFE_MODE_RST 8'h00
// ************************************************
// converter model
// ************************************************
`define AFE_OFFS_ZERO_INT 8'h40
`define AFE_OFFS_ZERO_EXT 8'h80
`define AFE_OFFS_STEP 32'sh00000010
`define AFE_GAIN_DEN 32'sh0000003F
`define AFE_GAIN_SLOPE 32'sh00000009
`define AFE_FULL_SCALE 32'sh0000FFFF
`define AFE_LAT_CLK 8
`define AFE_LAT_PIX 6
// ************************************************
// controller timing, in i_clk cycles
// ************************************************
`define AFE_CONV_HALF 8
`define AFE_SER_HALF 8
`define AFE_GUARD 4
`endif

// file: common/afe_pkg.sv
package afe_pkg;
  typedef enum logic [1:0] {COL_RED, COL_GRN, COL_BLU} colour_t;
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_BLO, S_BHI, S_TAIL, S_GAP} ser_state_t;
endpackage : afe_pkg

// file: common/afe_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface afe_link_if;
  logic conversion_clock;
  logic line_start_select;
  logic clamp;
  logic [7:0] dev_bus_o;
  logic dev_bus_oe;
  logic [7:0] ctl_bus_o;
  logic ctl_bus_oe;
  logic [7:0] bus;
  // undriven bus reads as pulled high
  assign bus = dev_bus_oe ? dev_bus_o : (ctl_bus_oe ? ctl_bus_o : 8'hFF);
  modport device (input conversion_clock, input line_start_select, input clamp, input bus,
                  output dev_bus_o, output dev_bus_oe);
  modport controller (output conversion_clock, output line_start_select, output clamp,
                      output ctl_bus_o, output ctl_bus_oe, input bus);
endinterface : afe_link_if
`default_nettype wire

// file: verilog/afe_device.sv
`timescale 1ns/1ns
`default_nettype none
`include "afe_regs.svh"
module afe_device
  import afe_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  afe_link_if.device link,
  input wire logic [15:0] i_red,
  input wire logic [15:0] i_grn,
  input wire logic [15:0] i_blu,
  input wire logic [15:0] i_dc_ext,
  output logic [5:0] o_gain_code,
  output logic [7:0] o_offset_code,
  output logic [1:0] o_channel,
  output logic o_top_ref_external,
  output logic o_dc_ref_external,
  output logic o_clamp_on,
  output logic o_tracking,
  output logic o_power_down
);
  // ************************************************
  // converter model
  // ************************************************
  function automatic logic [15:0] convert(input logic [15:0] smp, input logic [5:0] g,
                                          input logic [7:0] ofs, input logic top_ext,
                                          input logic inv, input logic [15:0] dcsub);
    logic signed [31:0] v;
    logic [7:0] zero;
    logic [15:0] r;
    zero = top_ext ? `AFE_OFFS_ZERO_EXT : `AFE_OFFS_ZERO_INT;
    v = $signed({16'h0000, smp}) - $signed({16'h0000, dcsub});
    // offset is added ahead of the gain stage, so it scales with gain
    v = v + ($signed({24'h000000, ofs}) - $signed({24'h000000, zero})) * `AFE_OFFS_STEP;
    v = (v * (`AFE_GAIN_DEN + $signed({26'h0000000, g}) * `AFE_GAIN_SLOPE)) / `AFE_GAIN_DEN;
    if (v < 32'sh00000000)
      r = 16'h0000;
    else if (v > `AFE_FULL_SCALE)
      r = 16'hFFFF;
    else
      r = v[15:0];
    convert = inv ? ~r : r;
  endfunction : convert

  // ************************************************
  // pin synchronisers
  // ************************************************
  // order: conversion clock, line start, clamp, load, serial data, shift clock
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [5:0] prev_r;
  always_ff @(posedge i_clk)
  begin
    s1_r <= {link.conversion_clock, link.line_start_select, link.clamp, link.bus[7:5]};
    s2_r <= s1_r;
    prev_r <= s2_r;
  end
  wire conv_s = s2_r[5];
  wire line_s = s2_r[4];
  wire clamp_s = s2_r[3];
  wire load_strobe = s2_r[2];
  wire serial_in = s2_r[1];
  wire shift_clock = s2_r[0];
  wire conv_fall = prev_r[5] & ~conv_s;
  wire conv_rise = ~prev_r[5] & conv_s;
  wire line_fall = prev_r[4] & ~line_s;
  wire load_fall = prev_r[2] & ~load_strobe;
  wire load_rise = ~prev_r[2] & load_strobe;
  wire shift_rise = ~prev_r[0] & shift_clock;

  // ************************************************
  // serial loader
  // ************************************************
  logic [10:0] shift_r;
  logic [3:0] cnt_r;
  logic active_r;
  // serial pins only mean something while line start is high
  wire ser_en = line_s;
  wire do_shift = ser_en & active_r & ~load_strobe & shift_rise & (cnt_r != `AFE_WORD_LAST);
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || !ser_en)
    begin
      active_r <= 1'b0;
      cnt_r <= 4'h0;
    end
    else if (load_fall)
    begin
      active_r <= 1'b1;
      cnt_r <= 4'h0;
    end
    else if (load_rise)
      active_r <= 1'b0;
    else if (do_shift)
      cnt_r <= cnt_r + 4'h1;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      shift_r <= 11'h000;
    else if (do_shift)
      shift_r <= {shift_r[9:0], serial_in};
  end
  // short sequences die here: no write without the full count
  wire wr_go = ser_en & active_r & load_rise & (cnt_r == `AFE_WORD_LAST);
  wire [2:0] wr_sel = shift_r[`AFE_SEL_MSB:`AFE_SEL_LSB];
  wire [7:0] wr_data = shift_r[`AFE_DATA_MSB:0];

  // ************************************************
  // register file
  // ************************************************
  logic [5:0] gain_r [3];
  logic [7:0] offs_r [3];
  logic [7:0] mode_r;
  wire wr_mode = wr_go & (wr_sel == `AFE_SEL_MODE);
  wire dig_reset = wr_mode & wr_data[`AFE_MODE_DIG_RESET];
  wire [1:0] wr_idx = wr_sel[2:1];
  // entering power-down loses the configuration; it is cleared so it is at least known
  wire [7:0] mode_in = wr_data[`AFE_MODE_PWR_DOWN] ?
                       {wr_data[7:2], 2'h0} : wr_data;
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || dig_reset)
    begin
      for (int i = 0; i < 3; i++)
      begin
        gain_r[i] <= `AFE_GAIN_RST;
        offs_r[i] <= `AFE_OFFS_RST;
      end
      mode_r <= `AFE_MODE_RST;
    end
    else if (wr_mode)
      mode_r <= mode_in;
    else if (wr_go && wr_sel != `AFE_SEL_NONE)
    begin
      if (wr_sel[0])
        offs_r[wr_idx] <= wr_data;
      else
        gain_r[wr_idx] <= wr_data[7:2];
    end
  end
  wire [1:0] cfg = mode_r[`AFE_MODE_CFG_MSB:`AFE_MODE_CFG_LSB];
  wire pwr_down = mode_r[`AFE_MODE_PWR_DOWN];
  wire top_ext = mode_r[`AFE_MODE_TOP_EXT];
  wire dc_ext = mode_r[`AFE_MODE_DC_EXT];

  // ************************************************
  // colour multiplexer
  // ************************************************
  colour_t colour_r;
  colour_t line_col_r;
  logic [15:0] hold_g_r;
  logic [15:0] hold_b_r;
  function automatic colour_t next_col(input colour_t c);
    next_col = (c == COL_RED) ? COL_GRN : ((c == COL_GRN) ? COL_BLU : COL_RED);
  endfunction : next_col
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || dig_reset || line_s)
      colour_r <= COL_RED;
    else if (conv_fall)
      colour_r <= next_col(colour_r);
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || dig_reset)
      line_col_r <= COL_RED;
    else if (line_fall && cfg == `AFE_CFG_ROT_LINE)
      line_col_r <= next_col(line_col_r);
  end
  // red edge of each triple is the simultaneous sample point
  wire triple = (cfg == `AFE_CFG_TRIPLE);
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      hold_g_r <= 16'h0000;
      hold_b_r <= 16'h0000;
    end
    else if (conv_fall && triple && colour_r == COL_RED)
    begin
      hold_g_r <= i_grn;
      hold_b_r <= i_blu;
    end
  end
  colour_t ch;
  logic [15:0] smp;
  always_comb
  begin
    ch = COL_RED;
    smp = i_red;
    case (cfg)
      `AFE_CFG_TRIPLE:
      begin
        ch = colour_r;
        smp = (colour_r == COL_RED) ? i_red : ((colour_r == COL_GRN) ? hold_g_r : hold_b_r);
      end
      `AFE_CFG_ROT_PIX: ch = colour_r;
      `AFE_CFG_ROT_LINE:
      begin
        ch = line_col_r;
        smp = (line_col_r == COL_RED) ? i_red : ((line_col_r == COL_GRN) ? i_grn : i_blu);
      end
      default: ch = COL_RED;
    endcase
  end
  wire [15:0] dcsub = dc_ext ? i_dc_ext : 16'h0000;
  wire [15:0] result = convert(smp, gain_r[ch], offs_r[ch], top_ext,
                               mode_r[`AFE_MODE_INVERT], dcsub);

  // ************************************************
  // latency pipe and byte output
  // ************************************************
  logic [`AFE_LAT_CLK-1:0][15:0] pipe_r;
  logic [15:0] word_r;
  logic [7:0] dout_r;
  wire clk_lat = (cfg == `AFE_CFG_RED) || (cfg == `AFE_CFG_ROT_LINE);
  wire [15:0] tap = clk_lat ? pipe_r[`AFE_LAT_CLK-1] : pipe_r[`AFE_LAT_PIX-1];
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      pipe_r <= '0;
      word_r <= 16'h0000;
      dout_r <= 8'h00;
    end
    else if (conv_fall && !pwr_down)
    begin
      pipe_r <= {pipe_r[`AFE_LAT_CLK-2:0], result};
      word_r <= tap;
      dout_r <= tap[15:8];
    end
    else if (conv_rise && !pwr_down)
      dout_r <= word_r[7:0];
  end
  assign link.dev_bus_o = dout_r;
  assign link.dev_bus_oe = ~line_s;

  // ************************************************
  // analog controls
  // ************************************************
  assign o_gain_code = gain_r[ch];
  assign o_offset_code = offs_r[ch];
  assign o_channel = ch;
  assign o_top_ref_external = top_ext;
  assign o_dc_ref_external = dc_ext;
  assign o_clamp_on = clamp_s & mode_r[`AFE_MODE_AC];
  assign o_tracking = ~clamp_s;
  assign o_power_down = pwr_down;
endmodule : afe_device
`default_nettype wire

// file: verilog/afe_controller.sv
`timescale 1ns/1ns
`default_nettype none
`include "afe_regs.svh"
module afe_controller
  import afe_pkg::*;
#(
  parameter int CONV_HALF = `AFE_CONV_HALF,
  parameter int SER_HALF = `AFE_SER_HALF
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  afe_link_if.controller link,
  input wire logic i_line_start,
  input wire logic i_clamp,
  input wire logic i_write,
  input wire logic [2:0] i_sel,
  input wire logic [7:0] i_data,
  output logic o_ready,
  output logic [15:0] o_result,
  output logic o_result_valid
);
  // ************************************************
  // conversion clock divider
  // ************************************************
  logic [7:0] div_r;
  logic conv_r;
  wire div_end = (div_r == 8'(CONV_HALF - 1));
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      div_r <= 8'h00;
      conv_r <= 1'b1;
    end
    else
    begin
      div_r <= div_end ? 8'h00 : div_r + 8'h01;
      if (div_end)
        conv_r <= ~conv_r;
    end
  end

  // ************************************************
  // line start, clamp and bus ownership
  // ************************************************
  logic line_r;
  logic clamp_r;
  logic [`AFE_GUARD-1:0] guard_r;
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      line_r <= 1'b1;
      clamp_r <= 1'b0;
      guard_r <= '0;
    end
    else
    begin
      line_r <= i_line_start;
      clamp_r <= i_clamp;
      guard_r <= {guard_r[`AFE_GUARD-2:0], line_r};
    end
  end
  // wait for the device to float the bus before driving it
  wire own_bus = line_r & (&guard_r);

  // ************************************************
  // byte demultiplexer
  // ************************************************
  logic [7:0] b1_r;
  logic [7:0] b2_r;
  logic [7:0] hi_r;
  logic hi_ok_r;
  logic [15:0] res_r;
  logic valid_r;
  always_ff @(posedge i_clk)
  begin
    b1_r <= link.bus;
    b2_r <= b1_r;
  end
  // sampling late in each half leaves room for the device's sync delay
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      hi_r <= 8'h00;
      hi_ok_r <= 1'b0;
      res_r <= 16'h0000;
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= 1'b0;
      if (line_r)
        hi_ok_r <= 1'b0;
      else if (div_end && !conv_r)
      begin
        hi_r <= b2_r;
        hi_ok_r <= 1'b1;
      end
      else if (div_end && conv_r && hi_ok_r)
      begin
        res_r <= {hi_r, b2_r};
        valid_r <= 1'b1;
        hi_ok_r <= 1'b0;
      end
    end
  end

  // ************************************************
  // serial writer
  // ************************************************
  ser_state_t st_r;
  logic [7:0] tmr_r;
  logic [3:0] bit_r;
  logic [10:0] word_r;
  logic load_r;
  logic shift_r;
  wire tmr_end = (tmr_r == 8'(SER_HALF - 1));
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || !own_bus)
    begin
      st_r <= S_IDLE;
      tmr_r <= 8'h00;
      bit_r <= 4'h0;
      word_r <= 11'h000;
      load_r <= 1'b1;
      shift_r <= 1'b0;
    end
    else
    begin
      tmr_r <= (st_r == S_IDLE || tmr_end) ? 8'h00 : tmr_r + 8'h01;
      case (st_r)
        S_IDLE:
          if (i_write)
          begin
            word_r <= {i_sel, i_data};
            bit_r <= 4'h0;
            load_r <= 1'b0;
            st_r <= S_LEAD;
          end
        S_LEAD: if (tmr_end) st_r <= S_BLO;
        S_BLO:
          if (tmr_end)
          begin
            shift_r <= 1'b1;
            st_r <= S_BHI;
          end
        S_BHI:
          if (tmr_end)
          begin
            shift_r <= 1'b0;
            word_r <= {word_r[9:0], 1'b0};
            bit_r <= bit_r + 4'h1;
            st_r <= (bit_r == `AFE_WORD_LAST - 4'h1) ? S_TAIL : S_BLO;
          end
        S_TAIL:
          if (tmr_end)
          begin
            load_r <= 1'b1;
            st_r <= S_GAP;
          end
        S_GAP: if (tmr_end) st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign link.conversion_clock = conv_r;
  assign link.line_start_select = line_r;
  assign link.clamp = clamp_r;
  assign link.ctl_bus_o = {load_r, word_r[10], shift_r, 5'h00};
  assign link.ctl_bus_oe = own_bus;
  assign o_ready = own_bus & (st_r == S_IDLE);
  assign o_result = res_r;
  assign o_result_valid = valid_r;
endmodule : afe_controller
`default_nettype wire

// file: tb/afe_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************
// wire checks on the link between the two ends
// ************************************************
module afe_link_properties (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic conversion_clock,
  input wire logic line_start_select,
  input wire logic clamp,
  input wire logic [7:0] dev_bus_o,
  input wire logic dev_bus_oe,
  input wire logic [7:0] ctl_bus_o,
  input wire logic ctl_bus_oe,
  input wire logic [7:0] bus
);
  logic shift_q_r;
  logic [3:0] shift_cnt_r;
  logic [3:0] shift_cnt_nxt;
  wire logic shift_rise = bus[5] & ~shift_q_r & ctl_bus_oe;
  wire logic cnt_step = shift_rise && (shift_cnt_r != 4'hF);
  // saturates, so a runaway shift clock never wraps back to eleven
  assign shift_cnt_nxt = bus[7] ? 4'h0 : shift_cnt_r + {3'h0, cnt_step};
  always_ff @(posedge i_clk)
  begin
    shift_q_r <= bus[5];
    shift_cnt_r <= i_rstn ? shift_cnt_nxt : 4'h0;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence shift_rise_s;
    ctl_bus_oe && $rose(bus[5]);
  endsequence
  sequence load_rise_s;
    ctl_bus_oe && line_start_select && $rose(bus[7]);
  endsequence
  bus_float_a: assert property (line_start_select[*4] |-> !dev_bus_oe)
    else $error("device drives bus during line start");
  bus_drive_a: assert property ((!line_start_select)[*4] |-> dev_bus_oe)
    else $error("device bus idle outside line start");
  one_driver_a: assert property (!(dev_bus_oe && ctl_bus_oe))
    else $error("both ends drive the bus");
  ctl_owner_a: assert property ($rose(ctl_bus_oe) |-> $past(line_start_select, 4))
    else $error("controller took bus too early");
  shift_framed_a: assert property (shift_rise_s |-> !bus[7])
    else $error("shift clock outside load frame");
  bit_settled_a: assert property (shift_rise_s |-> $stable(bus[6]))
    else $error("serial bit moved at shift edge");
  word_len_a: assert property (load_rise_s |-> shift_cnt_r == 4'hB)
    else $error("load ended without eleven shifts");
  byte_pace_a: assert property (dev_bus_oe && $changed(dev_bus_o)
    |-> $past(conversion_clock, 1) != $past(conversion_clock, 6))
    else $error("output byte changed without clock edge");
  conv_low_a: assert property ($fell(conversion_clock) |-> (!conversion_clock)[*4])
    else $error("conversion clock low half too short");
endmodule : afe_link_properties
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "afe_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
  import afe_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic line_start = 1'b1;
  logic clamp_in = 1'b0;
  logic write = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] data = 8'h00;
  logic [15:0] red, grn, blu, dc_ext, a, b, result;
  logic [5:0] gain_code, g2, g2_m;
  logic [7:0] offs_code, d, mode_m;
  logic [1:0] chan, p;
  logic top_ext, dc_o, clamp_on, tracking, pdown, ready, valid;
  logic [5:0] gain_m [3];
  logic [7:0] offs_m [3];
  integer failures = 0, check_count = 0, seed = 88678, n, k, i;
  always #25 i_clk = ~i_clk;
  afe_link_if link ();
  afe_link_if link2 ();
  afe_device afe_device_i (.i_clk(i_clk), .i_rstn(i_rstn), .link(link), .i_red(red),
    .i_grn(grn), .i_blu(blu), .i_dc_ext(dc_ext), .o_gain_code(gain_code),
    .o_offset_code(offs_code), .o_channel(chan), .o_top_ref_external(top_ext),
    .o_dc_ref_external(dc_o), .o_clamp_on(clamp_on), .o_tracking(tracking),
    .o_power_down(pdown));
  // second end fed by a hand-rolled driver that shifts short, long and exact counts
  afe_device afe_device_i2 (.i_clk(i_clk), .i_rstn(i_rstn), .link(link2), .i_red(red),
    .i_grn(grn), .i_blu(blu), .i_dc_ext(dc_ext), .o_gain_code(g2), .o_offset_code(),
    .o_channel(), .o_top_ref_external(), .o_dc_ref_external(), .o_clamp_on(),
    .o_tracking(), .o_power_down());
  afe_controller #(.CONV_HALF(`AFE_CONV_HALF), .SER_HALF(`AFE_SER_HALF)) afe_controller_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .link(link), .i_line_start(line_start),
    .i_clamp(clamp_in), .i_write(write), .i_sel(sel), .i_data(data), .o_ready(ready),
    .o_result(result), .o_result_valid(valid));
  afe_link_properties afe_link_properties_i (.i_clk(i_clk), .i_rstn(i_rstn),
    .conversion_clock(link.conversion_clock), .line_start_select(link.line_start_select),
    .clamp(link.clamp), .dev_bus_o(link.dev_bus_o), .dev_bus_oe(link.dev_bus_oe),
    .ctl_bus_o(link.ctl_bus_o), .ctl_bus_oe(link.ctl_bus_oe), .bus(link.bus));
  // ************************************************
  // tasks
  // ************************************************
  task automatic tick(input integer c);
    repeat (c) @(posedge i_clk);
  endtask : tick
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic wait_ready();
    integer w;
    w = 0;
    while (ready !== 1'b1 && w < 600)
    begin
      tick(1);
      w++;
    end
    if (w >= 600) failures++;
  endtask : wait_ready
  task automatic reset_m();
    gain_m = '{3{`AFE_GAIN_RST}};
    offs_m = '{3{`AFE_OFFS_RST}};
    mode_m = `AFE_MODE_RST;
  endtask : reset_m
  task automatic check_regs();
    `CHK(chan, 2'h0)
    `CHK(gain_code, gain_m[0])
    `CHK(offs_code, offs_m[0])
    `CHK({pdown, top_ext, dc_o}, {mode_m[7], mode_m[5:4]})
  endtask : check_regs
  task automatic wr(input logic [2:0] s, input logic [7:0] v);
    wait_ready();
    write <= 1'b1;
    sel <= s;
    data <= v;
    tick(1);
    write <= 1'b0;
    if (s == `AFE_SEL_MODE && v[`AFE_MODE_DIG_RESET]) reset_m();
    else if (s == `AFE_SEL_MODE) mode_m = v[7] ? {v[7:2], 2'h0} : v;
    else if (s != `AFE_SEL_NONE && s[0]) offs_m[s[2:1]] = v;
    else if (s != `AFE_SEL_NONE) gain_m[s[2:1]] = v[7:2];
    tick(2);
    wait_ready();
    tick(2);
    check_regs();
  endtask : wr
  task automatic clamp_check();
    clamp_in <= 1'b1;
    tick(6);
    `CHK({clamp_on, tracking}, {mode_m[3], 1'b0})
    clamp_in <= 1'b0;
    tick(6);
    `CHK({clamp_on, tracking}, 2'h1)
  endtask : clamp_check
  // bit order on the shared pins: load, serial, shift
  task automatic ser2(input logic [15:0] w, input integer cnt);
    link2.ctl_bus_o <= 8'h00;
    tick(6);
    for (i = 0; i < cnt; i++)
    begin
      link2.ctl_bus_o <= {1'b0, w[15 - i], 6'h00};
      tick(6);
      link2.ctl_bus_o <= {1'b0, w[15 - i], 6'h20};
      tick(6);
    end
    link2.ctl_bus_o <= 8'h00;
    tick(6);
    link2.ctl_bus_o <= 8'h80;
    tick(8);
    `CHK(g2, g2_m)
  endtask : ser2
  // integer model of the converter: dc reference, offset, gain, clipping, polarity
  function automatic logic [15:0] model(input logic [15:0] s, input integer g, input integer o,
                                        input logic [7:0] m);
    integer v;
    integer zero;
    zero = m[`AFE_MODE_TOP_EXT] ? integer'(`AFE_OFFS_ZERO_EXT) : integer'(`AFE_OFFS_ZERO_INT);
    v = integer'(s) - (m[`AFE_MODE_DC_EXT] ? integer'(dc_ext) : 0);
    v = v + (o - zero) * `AFE_OFFS_STEP;
    v = v * (`AFE_GAIN_DEN + g * `AFE_GAIN_SLOPE) / `AFE_GAIN_DEN;
    if (v < 0)
      v = 0;
    if (v > `AFE_FULL_SCALE)
      v = `AFE_FULL_SCALE;
    model = m[`AFE_MODE_INVERT] ? ~16'(v) : 16'(v);
  endfunction : model
  // switch mid pixel so the word in flight is unambiguous
  task automatic lat_check(input integer lat, input logic [15:0] v);
    line_start <= 1'b0;
    tick(12 * 16);
    @(posedge link.conversion_clock);
    red <= v;
    n = 0;
    k = 0;
    repeat (12 * 16)
    begin
      @(posedge i_clk);
      if (valid === 1'b1 && result === v) k = 1;
      else if (valid === 1'b1 && k == 0) n++;
    end
    `CHK(n, lat + 1)
    `CHK(k, 1)
    line_start <= 1'b1;
    tick(2);
  endtask : lat_check
  // held green and blue must follow live red, in that order
  task automatic triple_check();
    logic [15:0] trio [3];
    trio = '{red, grn, blu};
    line_start <= 1'b0;
    tick(12 * 16);
    @(posedge i_clk iff (valid === 1'b1 && result === red));
    for (k = 0; k < 6; k++)
    begin
      @(posedge i_clk iff valid === 1'b1);
      `CHK(result, trio[(k + 1) % 3])
    end
    line_start <= 1'b1;
    tick(2);
  endtask : triple_check
  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    red = 16'($random(seed));
    grn = 16'($random(seed));
    blu = 16'($random(seed));
    dc_ext = 16'($random(seed));
    a = red;
    b = ~a;
    {link2.conversion_clock, link2.line_start_select, link2.clamp} = 3'h6;
    link2.ctl_bus_o = 8'h80;
    link2.ctl_bus_oe = 1'b1;
    reset_m();
    tick(4);
    i_rstn <= 1'b1;
    tick(2);
    wait_ready();
    check_regs();
    clamp_check();
    $display("defaults done");
    line_start <= 1'b0;
    tick(12 * 16);
    @(posedge i_clk iff valid === 1'b1);
    `CHK(result, a)
    lat_check(`AFE_LAT_CLK, b);
    $display("latency done");
    for (n = 0; n < 8; n++)
      wr(n[2:0], 8'($random(seed)));
    wr(`AFE_SEL_MODE, 8'h01);
    line_start <= 1'b0;
    for (n = 0; n < 9; n++)
    begin
      @(posedge link.conversion_clock);
      tick(2);
      if (n > 0) `CHK(chan, (p == 2'h2) ? 2'h0 : p + 2'h1)
      `CHK({gain_code, offs_code}, {gain_m[chan], offs_m[chan]})
      p = chan;
    end
    line_start <= 1'b1;
    tick(6);
    `CHK(chan, 2'h0)
    $display("rotation done");
    wr(`AFE_SEL_MODE, 8'h38);
    clamp_check();
    wr(`AFE_SEL_MODE, 8'h83);
    wr(`AFE_SEL_MODE, 8'h00);
    wr(`AFE_SEL_MODE, 8'h40);
    $display("mode done");
    wr(3'h0, 8'h04);
    wr(3'h1, 8'h48);
    wr(`AFE_SEL_MODE, 8'h34);
    // dc reference at a quarter of red keeps the result clear of clipping
    dc_ext <= {2'h0, red[15:2]};
    line_start <= 1'b0;
    tick(12 * 16);
    @(posedge i_clk iff valid === 1'b1);
    `CHK(result, model(red, gain_m[0], offs_m[0], mode_m))
    line_start <= 1'b1;
    wr(`AFE_SEL_MODE, 8'h40);
    wr(`AFE_SEL_MODE, 8'h03);
    for (n = 1; n < 4; n++)
    begin
      line_start <= 1'b0;
      tick(6);
      `CHK(chan, 2'(n % 3))
      line_start <= 1'b1;
      tick(6);
    end
    wr(`AFE_SEL_MODE, 8'h01);
    lat_check(`AFE_LAT_PIX, a);
    wr(`AFE_SEL_MODE, 8'h02);
    triple_check();
    $display("conversion done");
    d = 8'($random(seed)) | 8'h80;
    g2_m = `AFE_GAIN_RST;
    ser2({3'h0, d, 5'h1F}, 10);
    g2_m = d[7:2];
    ser2({3'h0, d, 5'h1F}, 13);
    g2_m = ~d[7:2];
    ser2({3'h0, ~d, 5'h00}, 11);
    $display("shift count done");
    close_out();
  end
  initial
  begin
    #1000000;
    failures++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
